//--- fdsl_pkg.sv
// Shared constants and carrier types for the four digit segment latch driver.
package fdsl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Lows shorter than about one microsecond must not disable the driver.
    localparam int unsigned OSC_GLITCH_NS = 1000;
    localparam int unsigned OSC_GLITCH_CYCLES =
        (OSC_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned BP_DIVIDE = 128;
    localparam int unsigned BP_HALF = BP_DIVIDE / 2;
    localparam int unsigned OSC_NOMINAL_HZ = 19000;
    localparam int unsigned BP_NOMINAL_HZ = 150;

    // ------------------------------------------------------------------
    // Digit addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_MSD = 2'h0;
    localparam logic [1:0] ADDR_THIRD = 2'h1;
    localparam logic [1:0] ADDR_SECOND = 2'h2;
    localparam logic [1:0] ADDR_LSD = 2'h3;
    localparam logic [6:0] SEG_RESET = 7'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {FDSL_MODE_STROBE, FDSL_MODE_BUS} fdsl_mode_type;

    typedef struct packed {
        logic data_weight_eight;
        logic data_weight_four;
        logic data_weight_two;
        logic data_weight_one;
    } fdsl_data_type;

    typedef struct packed {
        logic digit_strobe_msd;
        logic digit_strobe_third;
        logic digit_strobe_second;
        logic digit_strobe_lsd;
    } fdsl_strobe_type;

    typedef struct packed {
        logic select_n_second;
        logic select_n_first;
        logic digit_addr_high;
        logic digit_addr_low;
    } fdsl_bus_type;

endpackage

//--- fdsl_decode.sv
// Four bit to seven segment decoder with hexadecimal and alternate tables.
`timescale 1ns/10ps
module fdsl_decode
(
    // Code in
    input wire logic [3:0] code,
    input wire logic alt,
    // Segments out, bit 0 is segment a
    output logic [6:0] seg
);

    always_comb
    begin
        unique case (code)
            4'h0: seg = 7'h3F;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5B;
            4'h3: seg = 7'h4F;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6D;
            4'h6: seg = 7'h7D;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7F;
            4'h9: seg = 7'h6F;
            4'hA: seg = alt ? 7'h40 : 7'h77;
            4'hB: seg = alt ? 7'h79 : 7'h7C;
            4'hC: seg = alt ? 7'h76 : 7'h39;
            4'hD: seg = alt ? 7'h38 : 7'h5E;
            4'hE: seg = alt ? 7'h73 : 7'h79;
            4'hF: seg = alt ? 7'h00 : 7'h71;
        endcase
    end

endmodule

//--- fdsl_top.sv
// Four digit segment latch driver with strobe or bus input and backplane.
`timescale 1ns/10ps
module fdsl_top
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Mode straps
    input wire fdsl_pkg::fdsl_mode_type MODE,
    input wire logic ALT_DECODE,
    // Data and selects
    input wire fdsl_pkg::fdsl_data_type DATA,
    input wire fdsl_pkg::fdsl_strobe_type STROBE,
    input wire fdsl_pkg::fdsl_bus_type BUS,
    // Oscillator
    input wire logic OSCILLATOR_PIN,
    // Backplane common, two-way
    input wire logic BACKPLANE_COMMON_I,
    output logic BACKPLANE_COMMON_O,
    output logic BACKPLANE_COMMON_OE_N,
    // Segments, four digits of seven, least significant digit first
    output logic [27:0] SEGMENTS
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 4 + 4 + 4 + 1 + 1;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync_in;
    fdsl_pkg::fdsl_data_type data_s;
    fdsl_pkg::fdsl_strobe_type strobe_s;
    fdsl_pkg::fdsl_bus_type bus_s;
    logic osc_s;
    logic bp_ext_s;

    assign sync_in = {DATA, STROBE, BUS, OSCILLATOR_PIN, BACKPLANE_COMMON_I};
    assign {data_s, strobe_s, bus_s, osc_s, bp_ext_s} = sync2_q;

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator low filter and divider
    // ------------------------------------------------------------------
    // Only a sustained low disables the driver, so a skewed overdrive clock
    // with short low parts keeps the backplane running.
    localparam int unsigned GL_CYC = fdsl_pkg::OSC_GLITCH_CYCLES;
    localparam int unsigned GL_W = $clog2(GL_CYC + 2);
    logic [GL_W-1:0] low_cnt_q;
    logic [GL_W-1:0] low_cnt_d;
    logic slave_q;
    logic slave_d;
    logic osc_prev_q;
    logic osc_prev_d;
    logic [6:0] div_q;
    logic [6:0] div_d;
    logic bp_int_q;
    logic bp_int_d;

    always_comb
    begin
        low_cnt_d = low_cnt_q;
        slave_d = slave_q;
        osc_prev_d = osc_s;
        div_d = div_q;
        bp_int_d = bp_int_q;
        if (osc_s)
        begin
            low_cnt_d = '0;
            slave_d = 1'b0;
        end
        else if (low_cnt_q > GL_W'(GL_CYC))
        begin
            slave_d = 1'b1;
        end
        else
        begin
            low_cnt_d = low_cnt_q + GL_W'(1);
        end
        // Each oscillator rising edge advances the divider.
        if (osc_s && !osc_prev_q)
        begin
            if (div_q == 7'(fdsl_pkg::BP_HALF - 1))
            begin
                div_d = 7'h00;
                bp_int_d = !bp_int_q;
            end
            else
            begin
                div_d = div_q + 7'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            low_cnt_q <= '0;
            slave_q <= 1'b0;
            osc_prev_q <= 1'b0;
            div_q <= 7'h00;
            bp_int_q <= 1'b0;
        end
        else
        begin
            low_cnt_q <= low_cnt_d;
            slave_q <= slave_d;
            osc_prev_q <= osc_prev_d;
            div_q <= div_d;
            bp_int_q <= bp_int_d;
        end
    end

    logic bp_phase;
    assign bp_phase = slave_q ? bp_ext_s : bp_int_q;
    assign BACKPLANE_COMMON_O = bp_int_q;
    assign BACKPLANE_COMMON_OE_N = slave_q;

    // ------------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------------
    logic [3:0] in_data_q;
    logic [3:0] in_data_d;
    logic [1:0] in_addr_q;
    logic [1:0] in_addr_d;
    logic sel_q;
    logic sel_d;
    logic [3:0] strobe_prev_q;
    logic [3:0] strobe_prev_d;
    logic both_low;
    logic [3:0] dig_we;
    logic [6:0] dec_seg;
    logic [3:0] dec_code;

    assign both_low = !bus_s.select_n_first && !bus_s.select_n_second;

    always_comb
    begin
        in_data_d = in_data_q;
        in_addr_d = in_addr_q;
        sel_d = both_low;
        strobe_prev_d = strobe_s;
        dig_we = 4'h0;
        if (both_low)
        begin
            in_data_d = data_s;
            in_addr_d = {bus_s.digit_addr_high, bus_s.digit_addr_low};
        end
        if (MODE == fdsl_pkg::FDSL_MODE_BUS)
        begin
            if (sel_q && !both_low)
            begin
                unique case (in_addr_q)
                    fdsl_pkg::ADDR_MSD: dig_we = 4'h8;
                    fdsl_pkg::ADDR_THIRD: dig_we = 4'h4;
                    fdsl_pkg::ADDR_SECOND: dig_we = 4'h2;
                    fdsl_pkg::ADDR_LSD: dig_we = 4'h1;
                endcase
            end
        end
        else
        begin
            // Level sensitive like the pad latch: decode while held high.
            dig_we = strobe_s;
        end
    end

    assign dec_code = (MODE == fdsl_pkg::FDSL_MODE_BUS) ? in_data_q : data_s;

    fdsl_decode u_decode
    (
        .code(dec_code),
        .alt(ALT_DECODE),
        .seg(dec_seg)
    );

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            in_data_q <= 4'h0;
            in_addr_q <= 2'h0;
            sel_q <= 1'b0;
            strobe_prev_q <= 4'h0;
        end
        else
        begin
            in_data_q <= in_data_d;
            in_addr_q <= in_addr_d;
            sel_q <= sel_d;
            strobe_prev_q <= strobe_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Digit output latches and segment drive
    // ------------------------------------------------------------------
    logic [6:0] digit_q [4];
    logic [6:0] digit_d [4];

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_digit
            always_comb
            begin
                digit_d[g] = digit_q[g];
                if (dig_we[g])
                begin
                    digit_d[g] = dec_seg;
                end
            end

            always_ff @(posedge REF_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    digit_q[g] <= fdsl_pkg::SEG_RESET;
                end
                else
                begin
                    digit_q[g] <= digit_d[g];
                end
            end

            assign SEGMENTS[g*7 +: 7] = digit_q[g] ^ {7{bp_phase}};

            a_seg_antiphase: assert property (@(posedge REF_CLK)
                disable iff (!NRST)
                !BACKPLANE_COMMON_OE_N |-> SEGMENTS[g*7 +: 7]
                == (digit_q[g] ^ {7{BACKPLANE_COMMON_O}}))
                else $error("Segment phase mismatch.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_bus_write_lsd: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        (MODE == fdsl_pkg::FDSL_MODE_BUS && sel_q && !both_low
        && in_addr_q == fdsl_pkg::ADDR_LSD)
        |=> digit_q[0] == $past(dec_seg))
        else $error("Bus write missed least digit.");
    a_addr_msd_map: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        (MODE == fdsl_pkg::FDSL_MODE_BUS && sel_q && !both_low
        && in_addr_q == fdsl_pkg::ADDR_MSD) |-> dig_we == 4'h8)
        else $error("Address 00 not most digit.");
    a_input_latch: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        both_low |=> in_data_q == $past(data_s))
        else $error("Input latch not loaded.");
    a_strobe_write: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        (MODE == fdsl_pkg::FDSL_MODE_STROBE && strobe_s.digit_strobe_msd)
        |=> digit_q[3] == $past(dec_seg))
        else $error("Strobe write missed.");
    a_hold_digit: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        !dig_we[1] |=> $stable(digit_q[1]))
        else $error("Digit changed without write.");
    a_slave_oe: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        (low_cnt_q > GL_W'(GL_CYC) && !osc_s) |=> BACKPLANE_COMMON_OE_N)
        else $error("Backplane not released.");
    a_glitch_ignore: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        ($fell(osc_s) && !slave_q) ##1 osc_s |=> !slave_q)
        else $error("Short low disabled driver.");
    a_slave_follow: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        slave_q |-> SEGMENTS[6:0] == (digit_q[0] ^ {7{bp_ext_s}}))
        else $error("Slave not following backplane.");
    a_div_toggle: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        $changed(bp_int_q) |-> $past(div_q) == 7'(fdsl_pkg::BP_HALF - 1))
        else $error("Backplane toggled off count.");

endmodule

//--- fdsl_partner.sv
// Host model: multiplexed digit source and processor bus writer.
`timescale 1ns/10ps
module fdsl_partner
(
    // Clock
    input wire logic clk,
    // Lines toward the device
    output fdsl_pkg::fdsl_data_type data,
    output fdsl_pkg::fdsl_strobe_type strobe,
    output fdsl_pkg::fdsl_bus_type bus
);
    // ----
    // Bus cycles
    // ----
    initial
    begin
        data = fdsl_pkg::fdsl_data_type'(4'h0);
        strobe = fdsl_pkg::fdsl_strobe_type'(4'h0);
        bus = fdsl_pkg::fdsl_bus_type'(4'hC);
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Released data shows its inverse so a late capture cannot pass.
    task automatic strobe_write(input int dig, input logic [3:0] code);
        @(negedge clk);
        data = fdsl_pkg::fdsl_data_type'(code);
        strobe = fdsl_pkg::fdsl_strobe_type'(4'h1 << dig);
        idle(4);
        strobe = fdsl_pkg::fdsl_strobe_type'(4'h0);
        idle(3);
        data = fdsl_pkg::fdsl_data_type'(~code);
        idle(3);
    endtask

    task automatic bus_write(input logic [1:0] addr, input logic [3:0] code,
                             input logic which);
        @(negedge clk);
        data = fdsl_pkg::fdsl_data_type'(code);
        bus = fdsl_pkg::fdsl_bus_type'({2'h0, addr});
        idle(4);
        if (which)
            bus.select_n_second = 1'b1;
        else
            bus.select_n_first = 1'b1;
        idle(3);
        bus = fdsl_pkg::fdsl_bus_type'({2'h3, ~addr});
        data = fdsl_pkg::fdsl_data_type'(~code);
        idle(4);
    endtask

    // One select alone never opens the input latches.
    task automatic bus_stray;
        @(negedge clk);
        bus.select_n_first = 1'b0;
        idle(4);
        bus.select_n_first = 1'b1;
        idle(4);
    endtask
endmodule

//--- tb_fdsl_top.sv
// Self-checking bench for the four digit segment latch driver.
`timescale 1ns/10ps
module tb_fdsl_top;
    // ----
    // Signals and model
    // ----
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    fdsl_pkg::fdsl_mode_type mode = fdsl_pkg::FDSL_MODE_STROBE;
    logic alt = 1'b0;
    fdsl_pkg::fdsl_data_type data;
    fdsl_pkg::fdsl_strobe_type strobe;
    fdsl_pkg::fdsl_bus_type bus;
    logic osc = 1'b1;
    logic osc_run = 1'b1;
    logic bp_in = 1'b0;
    logic bp_out;
    logic bp_oe_n;
    logic [27:0] segs;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 32'hc3e0b376;
    int r;
    int ph = 0;
    int osc_cnt = 0;
    int bp_ref = -1;
    int mg[4] = '{0, 0, 0, 0};
    logic [6:0] hex_t[16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
        7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    logic [6:0] alt_t[6] = '{7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};

    fdsl_top i_fdsl_top
    (
        .REF_CLK(ref_clk),
        .NRST(nrst),
        .MODE(mode),
        .ALT_DECODE(alt),
        .DATA(data),
        .STROBE(strobe),
        .BUS(bus),
        .OSCILLATOR_PIN(osc),
        .BACKPLANE_COMMON_I(bp_in),
        .BACKPLANE_COMMON_O(bp_out),
        .BACKPLANE_COMMON_OE_N(bp_oe_n),
        .SEGMENTS(segs)
    );

    fdsl_partner i_fdsl_partner
    (
        .clk(ref_clk),
        .data(data),
        .strobe(strobe),
        .bus(bus)
    );

    always #2.5 ref_clk = ~ref_clk;

    // Skewed overdrive: the low part lasts one cycle and must be ignored.
    always @(negedge ref_clk)
    begin
        ph = (ph + 1) % 8;
        osc <= osc_run ? (ph != 0) : 1'b0;
    end

    always @(posedge osc)
        osc_cnt++;

    always @(bp_out)
    begin
        // The first toggle after reset only sets the reference count.
        if (bp_oe_n === 1'b0 && nrst === 1'b1 && bp_ref >= 0)
            check(28'(osc_cnt - bp_ref), 28'h40);
        bp_ref = (nrst === 1'b1) ? osc_cnt : -1;
    end

    always @(posedge bp_oe_n)
        bp_ref = -1;

    // ----
    // Checks
    // ----
    function automatic int glyph(input logic a, input int c);
        if (a && c > 9)
            return alt_t[c - 10];
        return hex_t[c];
    endfunction

    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_segs;
        logic [27:0] e;
        logic p;
        p = (bp_oe_n === 1'b1) ? bp_in : bp_out;
        for (int g = 0; g < 4; g++)
            e[7 * g +: 7] = 7'(mg[g]) ^ {7{p}};
        check(segs, e);
    endtask

    task automatic stop_test;
        $display("TB: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        stop_test;
    end

    // ----
    // Scenarios
    // ----
    initial
    begin
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        i_fdsl_partner.idle(3);
        check_segs;
        for (int a = 0; a < 2; a++)
        begin
            alt = a[0];
            for (int c = 0; c < 20; c++)
            begin
                r = (c < 16) ? c : $random(seed);
                i_fdsl_partner.strobe_write(c % 4, r[3:0]);
                mg[c % 4] = glyph(alt, int'(r[3:0]));
                if (c >= 3)
                    check_segs;
            end
        end
        check(28'(bp_oe_n), 28'h0);
        mode = fdsl_pkg::FDSL_MODE_BUS;
        i_fdsl_partner.idle(4);
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            i_fdsl_partner.bus_write(k[1:0], r[3:0], k[2]);
            mg[3 - k % 4] = glyph(alt, int'(r[3:0]));
            check_segs;
        end
        i_fdsl_partner.strobe_write(0, 4'h8);
        check_segs;
        i_fdsl_partner.bus_stray;
        check_segs;
        // A slow external backplane stands in for a master device.
        // The low filter spans about 200 cycles, so 150 must not release.
        r = $random(seed);
        bp_in = r[0];
        osc_run = 1'b0;
        i_fdsl_partner.idle(150);
        check(28'(bp_oe_n), 28'h0);
        i_fdsl_partner.idle(70);
        check(28'(bp_oe_n), 28'h1);
        check_segs;
        bp_in = ~bp_in;
        i_fdsl_partner.idle(6);
        check_segs;
        osc_run = 1'b1;
        i_fdsl_partner.idle(10);
        check(28'(bp_oe_n), 28'h0);
        i_fdsl_partner.idle(1200);
        check_segs;
        stop_test;
    end
endmodule
